// file: logic/vaol_regs.svh
`ifndef VAOL_REGS_SVH
`define VAOL_REGS_SVH
`define VAOL_WORD_BITS      16
`define VAOL_FRAME_BITS     32
`define VAOL_CLK_HZ         25000000
`define VAOL_FLASH_MS       50
`define VAOL_FLASH_CYCLES   ((`VAOL_FLASH_MS * (`VAOL_CLK_HZ / 1000)))
`define VAOL_HEALTH_S       10
`define VAOL_HEALTH_CYCLES  (`VAOL_HEALTH_S * `VAOL_CLK_HZ)
`define VAOL_RESEND_S       3
`define VAOL_RESEND_CYCLES  (`VAOL_RESEND_S * `VAOL_CLK_HZ)
`define VAOL_HOLD_S         60
`define VAOL_HOLD_CYCLES    (`VAOL_HOLD_S * `VAOL_CLK_HZ)
`define VAOL_RADIO_BIT      13
`define VAOL_USER1_BIT      6
`define VAOL_USER2_BIT      2
`define VAOL_TIME_BIT       15
`define VAOL_EVAP_BIT       14
`define VAOL_REG_CTRL       4'h0
`define VAOL_REG_ALARMS     4'h1
`define VAOL_REG_STATUS     4'h2
`define VAOL_REG_IRQ_ENA    4'h3
`define VAOL_REG_IRQ_CLR    4'h4
`define VAOL_REG_GOOD_CNT   4'h5
`define VAOL_REG_SENT_CNT   4'h6
`endif

// file: logic/vaol_pkg.sv
package vaol_pkg;
    typedef enum logic [1:0] {
        vaol_idle_type_s,
        vaol_shift_type_s,
        vaol_gap_type_s
    } vaol_tx_state_type;
    typedef logic [15:0] vaol_word_type;
endpackage

// file: logic/vaol_link_if.sv
`timescale 1ns/1ps
interface vaol_link_if;
    logic serial_data;     // console to device data bit
    logic serial_shift;    // shift strobe with data, one bit per high cycle
    logic frame_end;       // one-cycle end-of-word mark
    logic strobe_return;   // device returns transfer strobe
    modport console (output serial_data, output serial_shift, output frame_end,
                     input strobe_return);
    modport device  (input serial_data, input serial_shift, input frame_end,
                     output strobe_return);
endinterface

// file: logic/vaol_device.sv
`timescale 1ns/1ps
`include "vaol_regs.svh"
module vaol_device #(
    parameter int unsigned FLASH_CYCLES  = `VAOL_FLASH_CYCLES,
    parameter int unsigned HEALTH_CYCLES = `VAOL_HEALTH_CYCLES
) (
    input  wire logic          clock,           // 25 mhz
    input  wire logic          rst,             // async, active high
    vaol_link_if.device        link,            // console side
    input  wire logic [3:0]    sel_a,           // bit select for a
    input  wire logic [3:0]    sel_b,           // bit select for b
    input  wire logic [3:0]    sel_c,           // bit select for c
    input  wire logic [3:0]    sel_d,           // bit select for d
    input  wire logic          enable_sw,       // enable switch, pin
    input  wire logic          normally_closed, // polarity jumper, pin
    input  wire logic          power_good,      // supply ok, pin
    output logic [15:0]        bit_select_field,// output register
    output logic [3:0]         contact,         // a..d closed when high
    output logic [3:0]         indicator,       // a..d lamps
    output logic [1:0]         latch_contact,   // first/second latch closed
    output logic [1:0]         latch_indicator, // latch lamps
    output logic               load_indicator,  // transfer flash
    output logic               health_contact,  // health closed
    output logic               health_lamp      // health lamp
);
    logic [31:0] shreg, next_shreg;
    logic [5:0]  count, next_count;
    logic [15:0] outreg, next_outreg;
    logic        strobe, next_strobe;
    logic [1:0]  latch, next_latch;
    logic [31:0] flash_cnt, next_flash_cnt;
    logic [31:0] health_cnt, next_health_cnt;
    logic [2:0]  en_s, pol_s, pwr_s;
    logic        en_q, pol_q, pwr_q;
    logic [3:0]  sel_bits;
    logic        good;

    function automatic logic pick(input logic [15:0] w, input logic [3:0] s);
        pick = w[s];
    endfunction

    // pin inputs: three stages, change accepted when last two agree
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            en_s  <= 3'h0;
            pol_s <= 3'h0;
            pwr_s <= 3'h0;
            en_q  <= 1'b0;
            pol_q <= 1'b0;
            pwr_q <= 1'b0;
        end else begin
            en_s  <= {en_s[1:0], enable_sw};
            pol_s <= {pol_s[1:0], normally_closed};
            pwr_s <= {pwr_s[1:0], power_good};
            if (en_s[1] == en_s[2]) en_q <= en_s[2];
            if (pol_s[1] == pol_s[2]) pol_q <= pol_s[2];
            if (pwr_s[1] == pwr_s[2]) pwr_q <= pwr_s[2];
        end
    end

    // true copy in upper half, inverted copy in lower half
    assign good = (count == 6'(`VAOL_FRAME_BITS))
                  && (shreg[31:16] == ~shreg[15:0]);

    always_comb begin
        next_shreg      = shreg;
        next_count      = count;
        next_outreg     = outreg;
        next_strobe     = 1'b0;
        next_latch      = latch;
        next_flash_cnt  = (flash_cnt != 32'h0) ? flash_cnt - 32'h1 : 32'h0;
        next_health_cnt = (health_cnt != 32'h0) ? health_cnt - 32'h1 : 32'h0;
        if (link.serial_shift) begin
            next_shreg = {shreg[30:0], link.serial_data};
            if (count != 6'h3f) next_count = count + 6'h1;
        end
        if (link.frame_end) begin
            next_count = 6'h0;
            if (good) begin
                next_outreg     = shreg[31:16];
                next_strobe     = 1'b1;
                next_flash_cnt  = FLASH_CYCLES;
                next_health_cnt = HEALTH_CYCLES;
            end
        end
        for (int i = 0; i < 2; i++) begin
            if (sel_bits[2*i+1]) next_latch[i] = 1'b0;
            else if (sel_bits[2*i]) next_latch[i] = 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            shreg      <= 32'h0;
            count      <= 6'h0;
            outreg     <= 16'h0;
            strobe     <= 1'b0;
            latch      <= 2'h0;
            flash_cnt  <= 32'h0;
            health_cnt <= 32'h0;
        end else begin
            shreg      <= next_shreg;
            count      <= next_count;
            outreg     <= next_outreg;
            strobe     <= next_strobe;
            latch      <= next_latch;
            flash_cnt  <= next_flash_cnt;
            health_cnt <= next_health_cnt;
        end
    end

    assign sel_bits = {pick(outreg, sel_d), pick(outreg, sel_c),
                       pick(outreg, sel_b), pick(outreg, sel_a)};

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            contact         <= 4'h0;
            indicator       <= 4'h0;
            latch_contact   <= 2'h0;
            latch_indicator <= 2'h0;
            load_indicator  <= 1'b0;
            health_contact  <= 1'b0;
            health_lamp     <= 1'b0;
        end else begin
            indicator       <= sel_bits;
            contact         <= en_q ? (pol_q ? ~sel_bits : sel_bits) : 4'h0;
            latch_contact   <= (en_q && !pol_q) ? latch : 2'h0;
            latch_indicator <= latch;
            load_indicator  <= (flash_cnt != 32'h0);
            health_contact  <= (health_cnt != 32'h0) && pwr_q && en_q;
            health_lamp     <= (health_cnt != 32'h0) && pwr_q && en_q;
        end
    end

    assign bit_select_field   = outreg;
    assign link.strobe_return = strobe;
endmodule

// file: logic/vaol_console.sv
`timescale 1ns/1ps
`include "vaol_regs.svh"
module vaol_console #(
    parameter int unsigned RESEND_CYCLES = `VAOL_RESEND_CYCLES,
    parameter int unsigned HOLD_CYCLES   = `VAOL_HOLD_CYCLES
) (
    input  wire logic          clock,         // 25 mhz
    input  wire logic          rst,           // async, active high
    vaol_link_if.console       link,          // device side
    input  wire logic [15:0]   alarm_level,   // live alarm conditions
    input  wire logic          time_trig,     // time alarm pulse
    input  wire logic          evap_trig,     // daily evap alarm pulse
    input  wire logic          radio_on,      // radio power request
    input  wire logic [3:0]    addr,          // register address
    input  wire logic [31:0]   wdata,         // write data
    input  wire logic          wr,            // write strobe
    input  wire logic          rd,            // read strobe
    output logic [31:0]        rdata,         // read data, cycle after rd
    output logic               irq            // level interrupt
);
    vaol_pkg::vaol_tx_state_type state, next_state;
    logic [31:0] frame, next_frame;
    logic [5:0]  bitn, next_bitn;
    logic [31:0] gap, next_gap;
    logic [31:0] time_hold, next_time_hold, evap_hold, next_evap_hold;
    logic [1:0]  user, next_user;
    logic [1:0]  status, next_status, irq_ena, next_irq_ena;
    logic [15:0] good_cnt, next_good_cnt, sent_cnt, next_sent_cnt;
    logic [31:0] next_rdata;
    vaol_pkg::vaol_word_type word;

    always_comb begin
        word = alarm_level;
        word[`VAOL_TIME_BIT]   = (time_hold != 32'h0);
        word[`VAOL_EVAP_BIT]   = (evap_hold != 32'h0);
        word[`VAOL_RADIO_BIT]  = radio_on;
        word[`VAOL_USER1_BIT]  = user[0];
        word[`VAOL_USER2_BIT]  = user[1];
    end

    always_comb begin
        next_state     = state;
        next_frame     = frame;
        next_bitn      = bitn;
        next_gap       = (gap != 32'h0) ? gap - 32'h1 : 32'h0;
        next_time_hold = time_trig ? HOLD_CYCLES
                         : ((time_hold != 32'h0) ? time_hold - 32'h1 : 32'h0);
        next_evap_hold = evap_trig ? HOLD_CYCLES
                         : ((evap_hold != 32'h0) ? evap_hold - 32'h1 : 32'h0);
        next_user      = user;
        next_irq_ena   = irq_ena;
        next_status    = status;
        next_good_cnt  = good_cnt;
        next_sent_cnt  = sent_cnt;
        next_rdata     = 32'h0;
        link.serial_data  = frame[31];
        link.serial_shift = 1'b0;
        link.frame_end    = 1'b0;
        unique case (state)
            vaol_pkg::vaol_idle_type_s: begin
                next_frame = {word, ~word};
                next_bitn  = 6'h0;
                next_state = vaol_pkg::vaol_shift_type_s;
            end
            vaol_pkg::vaol_shift_type_s: begin
                link.serial_shift = 1'b1;
                next_frame = {frame[30:0], 1'b0};
                next_bitn  = bitn + 6'h1;
                if (bitn == 6'(`VAOL_FRAME_BITS - 1)) begin
                    next_state = vaol_pkg::vaol_gap_type_s;
                    next_gap   = RESEND_CYCLES;
                end
            end
            vaol_pkg::vaol_gap_type_s: begin
                if (gap == RESEND_CYCLES) begin
                    link.frame_end = 1'b1;
                    next_sent_cnt  = sent_cnt + 16'h1;
                end
                if (gap == 32'h0) next_state = vaol_pkg::vaol_idle_type_s;
            end
        endcase
        if (wr && addr == `VAOL_REG_CTRL) next_user = wdata[1:0];
        if (wr && addr == `VAOL_REG_IRQ_ENA) next_irq_ena = wdata[1:0];
        if (wr && addr == `VAOL_REG_IRQ_CLR) next_status = status & ~wdata[1:0];
        if (link.strobe_return) begin
            next_good_cnt = good_cnt + 16'h1;
            next_status[0] = 1'b1;
        end
        if (link.frame_end) next_status[1] = 1'b1;
        if (rd) begin
            unique case (addr)
                `VAOL_REG_CTRL:     next_rdata = {30'h0, user};
                `VAOL_REG_ALARMS:   next_rdata = {16'h0, word};
                `VAOL_REG_STATUS:   next_rdata = {30'h0, status};
                `VAOL_REG_IRQ_ENA:  next_rdata = {30'h0, irq_ena};
                `VAOL_REG_GOOD_CNT: next_rdata = {16'h0, good_cnt};
                `VAOL_REG_SENT_CNT: next_rdata = {16'h0, sent_cnt};
                default:            next_rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state     <= vaol_pkg::vaol_idle_type_s;
            frame     <= 32'h0;
            bitn      <= 6'h0;
            gap       <= 32'h0;
            time_hold <= 32'h0;
            evap_hold <= 32'h0;
            user      <= 2'h0;
            status    <= 2'h0;
            irq_ena   <= 2'h0;
            good_cnt  <= 16'h0;
            sent_cnt  <= 16'h0;
            rdata     <= 32'h0;
        end else begin
            state     <= next_state;
            frame     <= next_frame;
            bitn      <= next_bitn;
            gap       <= next_gap;
            time_hold <= next_time_hold;
            evap_hold <= next_evap_hold;
            user      <= next_user;
            status    <= next_status;
            irq_ena   <= next_irq_ena;
            good_cnt  <= next_good_cnt;
            sent_cnt  <= next_sent_cnt;
            rdata     <= next_rdata;
        end
    end

    assign irq = |(status & irq_ena);
endmodule

// file: tb/vaol_asserts.sv
`timescale 1ns/1ps
module vaol_asserts (
    input wire logic clock,         // clock
    input wire logic rst,           // async reset
    input wire logic serial_data,   // link data
    input wire logic serial_shift,  // link shift strobe
    input wire logic frame_end,     // link end mark
    input wire logic strobe_return  // returned strobe
);
    logic [5:0]  cnt;
    logic [5:0]  next_cnt;
    logic [31:0] sh;
    logic [31:0] next_sh;
    always_comb begin
        next_cnt = frame_end ? 6'h0 : cnt + {5'h0, serial_shift};
        next_sh  = serial_shift ? {sh[30:0], serial_data} : sh;
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt <= 6'h0;
            sh  <= 32'h0;
        end else begin
            cnt <= next_cnt;
            sh  <= next_sh;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    property p_count; frame_end |-> cnt == 6'h20; endproperty
    a_count: assert property (p_count)
        else $error("frame end without 32 shifts");
    property p_pair; frame_end |-> sh[31:16] == ~sh[15:0]; endproperty
    a_pair: assert property (p_pair)
        else $error("second copy not inverted");
    property p_run; $rose(serial_shift) |-> serial_shift [*8]; endproperty
    a_run: assert property (p_run)
        else $error("shift run broken");
    property p_close; $fell(serial_shift) |-> frame_end; endproperty
    a_close: assert property (p_close)
        else $error("shift run not closed by frame end");
    property p_answer; frame_end |=> strobe_return; endproperty
    a_answer: assert property (p_answer)
        else $error("good frame without strobe");
    property p_cause; strobe_return |-> $past(frame_end); endproperty
    a_cause: assert property (p_cause)
        else $error("strobe without frame end");
    property p_pulse; strobe_return |=> !strobe_return; endproperty
    a_pulse: assert property (p_pulse)
        else $error("strobe longer than one cycle");
    property p_resend; frame_end |=> !serial_shift [*8] ##[1:300] serial_shift; endproperty
    a_resend: assert property (p_resend)
        else $error("resend spacing wrong");
    property p_idle; frame_end |-> !serial_shift; endproperty
    a_idle: assert property (p_idle)
        else $error("shift during frame end");
endmodule

// file: tb/vaol_bench.sv
`timescale 1ns/1ps
module vaol_bench;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [15:0] alarm_level = 16'h0;
    logic        time_trig = 1'b0;
    logic        evap_trig = 1'b0;
    logic        radio_on = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [31:0] rdata;
    logic        irq;
    logic [3:0]  sel [4] = '{4'h0, 4'h1, 4'h2, 4'h3};
    logic        en = 1'b1;
    logic        nc = 1'b0;
    logic        pg = 1'b1;
    logic [15:0] bsf;
    logic [15:0] bsf2;
    logic [3:0]  contact;
    logic [3:0]  ind;
    logic [3:0]  sb;
    logic [1:0]  lc;
    logic [1:0]  lat = 2'h0;
    logic        ld;
    logic        hl;
    logic        strobe_d = 1'b0;
    logic        strobe_dd = 1'b0;
    logic        strobe2_d = 1'b0;
    logic [1:0]  li;
    logic        hc;
    logic [3:0]  con2;
    logic [3:0]  ind2;
    logic [3:0]  sb2;
    logic        ld2;
    logic        hl2;
    logic        rd_d = 1'b0;
    logic [31:0] seed = 32'h57fef840;
    logic [15:0] wq [$];
    logic [15:0] wq2 [$];
    logic [31:0] rq [$];
    int          fail_count = 0;
    int          check_count = 0;
    int          cyc = 0;
    int          n2 = 0;
    vaol_link_if link ();
    vaol_link_if link2 ();
    always #20 clock = ~clock;
    vaol_console #(.RESEND_CYCLES(100), .HOLD_CYCLES(120)) vaol_console_i (.clock(clock),
        .rst(rst), .link(link), .alarm_level(alarm_level), .time_trig(time_trig),
        .evap_trig(evap_trig), .radio_on(radio_on), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .irq(irq));
    vaol_device #(.FLASH_CYCLES(20), .HEALTH_CYCLES(200)) vaol_device_i (.clock(clock),
        .rst(rst), .link(link), .sel_a(sel[0]), .sel_b(sel[1]), .sel_c(sel[2]), .sel_d(sel[3]),
        .enable_sw(en), .normally_closed(nc), .power_good(pg), .bit_select_field(bsf),
        .contact(contact), .indicator(ind), .latch_contact(lc), .latch_indicator(li),
        .load_indicator(ld), .health_contact(hc), .health_lamp(hl));
    vaol_device #(.FLASH_CYCLES(20), .HEALTH_CYCLES(200)) vaol_device_i2 (.clock(clock),
        .rst(rst), .link(link2), .sel_a(sel[0]), .sel_b(sel[1]), .sel_c(sel[2]), .sel_d(sel[3]),
        .enable_sw(en), .normally_closed(nc), .power_good(pg), .bit_select_field(bsf2),
        .contact(con2), .indicator(ind2), .latch_contact(), .latch_indicator(),
        .load_indicator(ld2), .health_contact(), .health_lamp(hl2));
    vaol_asserts vaol_asserts_i (.clock(clock), .rst(rst), .serial_data(link.serial_data),
        .serial_shift(link.serial_shift), .frame_end(link.frame_end),
        .strobe_return(link.strobe_return));
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic reg_op(input logic w, input logic [3:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= ~w;
        if (!w) rq.push_back(d);
        @(posedge clock);
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clock);
    endtask
    task automatic send2(input logic [63:0] f, input int n);
        for (int k = n - 1; k >= 0; k--) begin
            link2.serial_shift <= 1'b1;
            link2.serial_data <= f[k];
            @(posedge clock);
        end
        link2.serial_shift <= 1'b0;
        link2.frame_end <= 1'b1;
        link2.serial_data <= ~f[0];
        @(posedge clock);
        link2.frame_end <= 1'b0;
        repeat (4) @(posedge clock);
    endtask
    // result watcher, also models the two latches
    always @(posedge clock) begin
        sb = {bsf[sel[3]], bsf[sel[2]], bsf[sel[1]], bsf[sel[0]]};
        lat[0] = sb[1] ? 1'b0 : (sb[0] | lat[0]);
        lat[1] = sb[3] ? 1'b0 : (sb[2] | lat[1]);
        if (rst) lat = 2'h0;
        if (rd_d) check(rdata, rq.pop_front());
        if (link.strobe_return) check({16'h0, bsf}, {16'h0, wq.pop_front()});
        if (link2.strobe_return) n2++;
        if (link2.strobe_return) check({16'h0, bsf2}, {16'h0, wq2.pop_front()});
        if (strobe_d) begin
            check({28'h0, ind}, {28'h0, sb});
            check({28'h0, contact}, {28'h0, en ? (nc ? ~sb : sb) : 4'h0});
            check({29'h0, ld, hl, hc}, {29'h0, 1'b1, en & pg, en & pg});
        end
        // latches follow the output register one cycle later
        if (strobe_dd) begin
            check({30'h0, lc}, {30'h0, (en & ~nc) ? lat : 2'h0});
            check({30'h0, li}, {30'h0, lat});
        end
        if (strobe2_d) begin
            sb2 = {bsf2[sel[3]], bsf2[sel[2]], bsf2[sel[1]], bsf2[sel[0]]};
            check({28'h0, ind2}, {28'h0, sb2});
            check({28'h0, con2}, {28'h0, en ? (nc ? ~sb2 : sb2) : 4'h0});
            check({30'h0, ld2, hl2}, {30'h0, 1'b1, en & pg});
        end
        strobe_d <= link.strobe_return;
        strobe_dd <= strobe_d;
        strobe2_d <= link2.strobe_return;
        rd_d <= rd;
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            conclude();
        end
    end
    initial begin
        logic [31:0] s;
        logic [1:0]  u;
        logic [15:0] w;
        u = 2'h0;
        w = 16'h0;
        link2.serial_data = 1'b0;
        link2.serial_shift = 1'b0;
        link2.frame_end = 1'b0;
        wq.push_back(16'h0);
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        for (int i = 0; i < 12; i++) begin
            @(posedge clock iff link.strobe_return);
            repeat (3) @(posedge clock);
            s = xs(seed);
            seed = xs(s);
            alarm_level <= s[15:0];
            radio_on <= s[16];
            en <= s[17];
            nc <= s[18];
            pg <= s[19];
            for (int k = 0; k < 4; k++) sel[k] <= seed[4*k +: 4];
            case (i)
                1: begin
                    reg_op(1'b1, 4'h4, 32'h3);
                    reg_op(1'b1, 4'h3, 32'h1);
                    reg_op(1'b0, 4'h2, 32'h0);
                    reg_op(1'b0, 4'hf, 32'h0);
                    check({31'h0, irq}, 32'h0);
                end
                2: begin
                    check({31'h0, irq}, 32'h1);
                    reg_op(1'b0, 4'h2, 32'h3);
                    reg_op(1'b0, 4'h5, 32'h3);
                    reg_op(1'b1, 4'h4, 32'h1);
                    check({31'h0, irq}, 32'h0);
                    reg_op(1'b0, 4'h2, 32'h2);
                end
                3, 6: begin
                    u = (i == 3) ? 2'h3 : 2'h0;
                    reg_op(1'b1, 4'h0, {30'h0, u});
                    reg_op(1'b0, 4'h0, {30'h0, u});
                end
                5: begin
                    time_trig <= 1'b1;
                    evap_trig <= 1'b1;
                    @(posedge clock);
                    time_trig <= 1'b0;
                    evap_trig <= 1'b0;
                end
                default: ;
            endcase
            w = (s[15:0] & 16'h1fbb) | {2'h0, s[16], 6'h0, u[0], 3'h0, u[1], 2'h0}
                | ((i == 5) ? 16'hc000 : 16'h0);
            wq.push_back(w);
        end
        // console keeps resending the last word while the second link runs
        wq.push_back(w);
        wq.push_back(w);
        @(posedge clock iff link.strobe_return);
        wq2.push_back(16'h1234);
        send2({32'h0, 16'h1234, 16'hedcb}, 32);
        send2({32'h0, 16'h5555, 16'haaab}, 32);
        send2({32'h0, 16'h0f0f, 16'hf0f0}, 31);
        send2({31'h0, 1'b1, 16'h0f0f, 16'hf0f0}, 33);
        check({16'h0, bsf2}, 32'h1234);
        wq2.push_back(16'h8001);
        send2({32'h0, 16'h8001, 16'h7ffe}, 32);
        check(n2, 2);
        conclude();
    end
endmodule
